// ==== core/dpr_regmap.sv ====
// register map, error flag and terminal switch control of the digital potentiometer
`timescale 1ns/1ps
`default_nettype none
`include "dpr_consts.svh"
module dpr_regmap #(
	parameter bit SEVEN_BIT = 1'b0
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire logic cs_n_i,
	input wire logic cmd_valid_i,
	input wire dpr_pkg::dpr_cmd_t cmd_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic hw_shutdown_n_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic command_error_o,
	output logic [7:0] wiper_code_o,
	output dpr_pkg::dpr_switch_t switch_o
);
	// ****************************************
	// decode
	// ****************************************
	localparam logic [7:0] FULL = SEVEN_BIT ? `DPR_FULL_7 : `DPR_FULL_8;
	localparam logic [7:0] MID = SEVEN_BIT ? `DPR_MID_7 : `DPR_MID_8;
	logic [7:0] wiper_q, wiper_d;
	logic [3:0] terminal_connect_control_q;
	logic [3:0] terminal_connect_control_live_q;
	logic err_q, cs_q, rearm_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	dpr_pkg::dpr_switch_t sw_q, sw_d;
	wire hit_wiper = addr_i == `DPR_ADDR_WIPER;
	wire hit_terminal_connect_control = addr_i == `DPR_ADDR_TERMINAL_CONNECT_CONTROL;
	wire is_rw = cmd_i == dpr_pkg::DPR_CMD_READ || cmd_i == dpr_pkg::DPR_CMD_WRITE;
	// commands are ignored while in error and outside a frame
	wire live = cmd_valid_i && !cs_n_i && !err_q && en_i;
	wire allowed = hit_wiper || (hit_terminal_connect_control && is_rw);
	wire take = live && allowed;
	wire bad = live && !allowed;
	wire wr_terminal_connect_control = take && hit_terminal_connect_control && cmd_i == dpr_pkg::DPR_CMD_WRITE;
	wire cs_fall = cs_q && !cs_n_i;
	wire [7:0] terminal_connect_control_full = {`DPR_TERMINAL_CONNECT_CONTROL_RSVD, terminal_connect_control_q};
	wire forced = !hw_shutdown_n_i || !terminal_connect_control_live_q[`DPR_BIT_SOFT_HW_SHUTDOWN_N];
	// a read hands back the wiper or the padded terminal control word
	wire rd_take = take && cmd_i == dpr_pkg::DPR_CMD_READ;
	wire [7:0] rd_word = hit_wiper ? wiper_q : terminal_connect_control_full;
	// the stored bits reach the switches only between frames
	wire terminal_connect_control_apply = cs_n_i;
	always_comb
	begin
		wiper_d = wiper_q;
		if (take && hit_wiper)
		begin
			unique case (cmd_i)
				dpr_pkg::DPR_CMD_WRITE: wiper_d = wdata_i & FULL;
				dpr_pkg::DPR_CMD_INCR: wiper_d = (wiper_q == FULL) ? wiper_q : 8'(wiper_q + 8'h01);
				dpr_pkg::DPR_CMD_DECR: wiper_d = (wiper_q == 8'h00) ? wiper_q : 8'(wiper_q - 8'h01);
				dpr_pkg::DPR_CMD_READ: wiper_d = wiper_q;
			endcase
		end
	end
	always_comb
	begin
		sw_d.term_a = terminal_connect_control_live_q[`DPR_BIT_TERM_A];
		sw_d.term_w = terminal_connect_control_live_q[`DPR_BIT_TERM_W];
		sw_d.term_b = terminal_connect_control_live_q[`DPR_BIT_TERM_B];
		if (forced)
		begin
			// shutdown: A open, W tied to B
			sw_d.term_a = 1'b0;
			sw_d.term_w = 1'b1;
			sw_d.term_b = 1'b1;
		end
	end
	// ****************************************
	// registers
	// ****************************************
	// chip select history for the error clear edge
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cs_q <= 1'b1;
		else if (en_i)
			cs_q <= cs_n_i;
	end

	// the wiper powers up at mid-scale of the chosen resolution
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			wiper_q <= MID;
		else if (en_i)
			wiper_q <= wiper_d;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			terminal_connect_control_q <= `DPR_TERMINAL_CONNECT_CONTROL_RESET_LO;
		else if (en_i && wr_terminal_connect_control)
			terminal_connect_control_q <= wdata_i[3:0];
	end

	// shadow copy so a half-written frame never moves the switches
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			terminal_connect_control_live_q <= `DPR_TERMINAL_CONNECT_CONTROL_RESET_LO;
		else if (en_i && terminal_connect_control_apply)
			terminal_connect_control_live_q <= terminal_connect_control_q;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sw_q <= 3'h7;
		else if (en_i)
			sw_q <= sw_d;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			err_q <= 1'b0;
		else if (en_i)
		begin
			// error set wins over the clearing chip select edge
			if (bad)
				err_q <= 1'b1;
			else if (cs_fall && rearm_q)
				err_q <= 1'b0;
		end
	end

	// a high chip select only counts once the error is already up
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rearm_q <= 1'b0;
		else if (en_i)
		begin
			if (bad)
				rearm_q <= 1'b0;
			else if (err_q && cs_n_i)
				rearm_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else if (en_i)
		begin
			rvalid_q <= rd_take;
			if (rd_take)
				rdata_q <= rd_word;
		end
	end
	assign rdata_o = rdata_q;
	assign rvalid_o = rvalid_q;
	assign command_error_o = err_q;
	assign wiper_code_o = wiper_q;
	assign switch_o = sw_q;
	// ****************************************
	// checks
	// ****************************************
	a_reserved_err: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && bad) |=> command_error_o && $stable(wiper_q) && $stable(terminal_connect_control_q))
		else $error("reserved access did not raise error");
	a_err_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(err_q && !(en_i && cs_fall && rearm_q)) |=> err_q)
		else $error("error cleared without chip select cycle");
	a_wiper_ok: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(live && hit_wiper) |=> !err_q)
		else $error("wiper command raised error");
	a_terminal_connect_control_incr_err: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(live && hit_terminal_connect_control && !is_rw) |=> err_q)
		else $error("terminal control step not refused");
	a_terminal_connect_control_late: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && !cs_n_i) |=> $stable(terminal_connect_control_live_q))
		else $error("terminal control applied mid command");
	a_rsvd_ones: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rvalid_q && $past(hit_terminal_connect_control) |-> rdata_q[7:4] == 4'hF)
		else $error("reserved bits not one");
	a_hw_shutdown_n_cfg: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && !hw_shutdown_n_i) |=> sw_q == 3'b011)
		else $error("shutdown configuration wrong");
	a_no_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(take && hit_wiper && cmd_i == dpr_pkg::DPR_CMD_INCR && wiper_q == FULL)
		|=> wiper_q == FULL)
		else $error("wiper wrapped");
	a_terminal_connect_control_keep_wiper: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wr_terminal_connect_control |=> $stable(wiper_q))
		else $error("terminal write changed wiper");
	c_error_clear: cover property (@(posedge clk_i) disable iff (!nrst_i)
		err_q ##[1:40] !err_q);
	c_terminal_connect_control_write: cover property (@(posedge clk_i) disable iff (!nrst_i) wr_terminal_connect_control);
	c_soft_hw_shutdown_n: cover property (@(posedge clk_i) disable iff (!nrst_i)
		!terminal_connect_control_live_q[`DPR_BIT_SOFT_HW_SHUTDOWN_N]);
	c_hw_hw_shutdown_n: cover property (@(posedge clk_i) disable iff (!nrst_i)
		!hw_shutdown_n_i && take && hit_wiper);
	c_read_terminal_connect_control: cover property (@(posedge clk_i) disable iff (!nrst_i)
		rvalid_q && rdata_q[7:4] == 4'hF);

	// ****************************************
	// checks on the switch network
	// ****************************************
	// each connect bit drives its own switch whenever nothing forces shutdown
	a_term_a_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && !forced) |=> sw_q.term_a == $past(terminal_connect_control_live_q[`DPR_BIT_TERM_A]))
		else $error("terminal A switch does not follow its bit");

	a_term_w_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && !forced) |=> sw_q.term_w == $past(terminal_connect_control_live_q[`DPR_BIT_TERM_W]))
		else $error("wiper switch does not follow its bit");

	a_term_b_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && !forced) |=> sw_q.term_b == $past(terminal_connect_control_live_q[`DPR_BIT_TERM_B]))
		else $error("terminal B switch does not follow its bit");

	a_soft_hw_shutdown_n: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && !terminal_connect_control_live_q[`DPR_BIT_SOFT_HW_SHUTDOWN_N]) |=> sw_q == 3'b011)
		else $error("soft shutdown configuration wrong");

	// the stored connect bits must survive either kind of shutdown
	a_hw_shutdown_n_keeps_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && forced && !wr_terminal_connect_control) |=> $stable(terminal_connect_control_q))
		else $error("shutdown changed stored connect bits");

	a_pin_keeps_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && !hw_shutdown_n_i && !wr_terminal_connect_control) |=> $stable(terminal_connect_control_q))
		else $error("shutdown pin changed stored bits");

	a_stored_apply: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_i && cs_n_i) |=> terminal_connect_control_live_q == $past(terminal_connect_control_q))
		else $error("terminal control not applied after the command");

	// ****************************************
	// checks on the wiper
	// ****************************************
	a_no_underflow: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(take && hit_wiper && cmd_i == dpr_pkg::DPR_CMD_DECR && wiper_q == 8'h00) |=> wiper_q == 8'h00)
		else $error("wiper wrapped below zero");

	a_incr_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(take && hit_wiper && cmd_i == dpr_pkg::DPR_CMD_INCR && wiper_q != FULL)
		|=> wiper_q == 8'($past(wiper_q) + 8'h01))
		else $error("increment did not step the wiper");

	a_decr_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(take && hit_wiper && cmd_i == dpr_pkg::DPR_CMD_DECR && wiper_q != 8'h00)
		|=> wiper_q == 8'($past(wiper_q) - 8'h01))
		else $error("decrement did not step the wiper");

	// the mask keeps the 7-bit variant from holding codes above its top tap
	a_wiper_cap: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wiper_q <= FULL)
		else $error("wiper code beyond full scale");

	a_hw_shutdown_n_serial: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(take && hit_wiper && cmd_i == dpr_pkg::DPR_CMD_WRITE && !hw_shutdown_n_i)
		|=> wiper_q == ($past(wdata_i) & FULL))
		else $error("write lost during shutdown");

	a_read_data: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(rvalid_q && $past(hit_wiper)) |-> rdata_q == $past(wiper_q))
		else $error("wiper read returned wrong data");

	// ****************************************
	// checks on the error flag
	// ****************************************
	a_terminal_connect_control_rw_ok: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(live && hit_terminal_connect_control && is_rw) |=> !err_q)
		else $error("terminal control access raised error");

	a_reserved_any: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(live && !hit_wiper && !hit_terminal_connect_control) |=> err_q)
		else $error("reserved access not refused");

	// while the error stands nothing may reach the registers
	a_err_blocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
		err_q |-> !take)
		else $error("command taken while in error");

	// a low enable must freeze every piece of state
	a_freeze_state: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!en_i |=> $stable(wiper_q) && $stable(err_q) && $stable(terminal_connect_control_q)
		&& $stable(terminal_connect_control_live_q) && $stable(sw_q))
		else $error("state moved while enable low");
endmodule : dpr_regmap
`default_nettype wire

// ==== core/dpr_consts.svh ====
// constants for the digital potentiometer register map
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH
`define DPR_ADDR_WIPER 4'h0
`define DPR_ADDR_TERMINAL_CONNECT_CONTROL 4'h4
`define DPR_TERMINAL_CONNECT_CONTROL_RESET 8'hFF
`define DPR_TERMINAL_CONNECT_CONTROL_RESET_LO 4'hF
`define DPR_TERMINAL_CONNECT_CONTROL_RSVD 4'hF
`define DPR_BIT_SOFT_HW_SHUTDOWN_N 3
`define DPR_BIT_TERM_A 2
`define DPR_BIT_TERM_W 1
`define DPR_BIT_TERM_B 0
`define DPR_MID_8 8'h7F
`define DPR_MID_7 8'h3F
`define DPR_FULL_8 8'hFF
`define DPR_FULL_7 8'h7F
`endif

// ==== core/dpr_pkg.sv ====
// types for the digital potentiometer register map
package dpr_pkg;
	typedef enum logic [1:0] {
		DPR_CMD_WRITE = 2'h0,
		DPR_CMD_INCR = 2'h1,
		DPR_CMD_DECR = 2'h2,
		DPR_CMD_READ = 2'h3
	} dpr_cmd_t;
	typedef struct packed {
		logic term_a;
		logic term_w;
		logic term_b;
	} dpr_switch_t;
endpackage : dpr_pkg

// ==== verification/dpr_host_model.sv ====
// spi host stand-in that frames commands for the register map
`timescale 1ns/1ps
`default_nettype none
module dpr_host_model (
	input wire logic clk_i,
	output logic cs_n_o,
	output logic cmd_valid_o,
	output dpr_pkg::dpr_cmd_t cmd_o,
	output logic [3:0] addr_o,
	output logic [7:0] wdata_o
);
	initial
	begin
		cs_n_o = 1'b1;
		cmd_valid_o = 1'b0;
		cmd_o = dpr_pkg::DPR_CMD_READ;
		addr_o = 4'h0;
		wdata_o = 8'h00;
	end
	task automatic xfer(input dpr_pkg::dpr_cmd_t c, input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_i);
		cs_n_o = 1'b0;
		cmd_valid_o = 1'b1;
		cmd_o = c;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		cmd_valid_o = 1'b0;
		// stale fields are inverted so a late sample cannot pass by luck
		addr_o = ~a;
		wdata_o = ~d;
	endtask : xfer
	// two high cycles end the command and arm the error clear
	task automatic frame_end();
		@(negedge clk_i);
		cs_n_o = 1'b1;
		repeat (2) @(negedge clk_i);
		cs_n_o = 1'b0;
	endtask : frame_end
endmodule : dpr_host_model
`default_nettype wire

// ==== verification/dpr_regmap_tb.sv ====
// self-checking bench for the potentiometer register map
`timescale 1ns/1ps
`default_nettype none
module dpr_regmap_tb;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic en_i = 1'b1;
	logic hw_shutdown_n_i = 1'b1;
	logic cs_n, cmd_valid, rvalid_o, command_error_o, rv;
	dpr_pkg::dpr_cmd_t cmd;
	logic [3:0] addr;
	logic [7:0] wdata, rdata_o, wiper_code_o, got, wiper7;
	dpr_pkg::dpr_switch_t switch_o;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	initial forever #25 clk_i = ~clk_i;
	dpr_host_model u_host (.clk_i(clk_i), .cs_n_o(cs_n), .cmd_valid_o(cmd_valid),
		.cmd_o(cmd), .addr_o(addr), .wdata_o(wdata));
	dpr_regmap u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .cs_n_i(cs_n),
		.cmd_valid_i(cmd_valid), .cmd_i(cmd), .addr_i(addr), .wdata_i(wdata),
		.hw_shutdown_n_i(hw_shutdown_n_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.command_error_o(command_error_o), .wiper_code_o(wiper_code_o), .switch_o(switch_o));
	// 7-bit variant fed the same commands, only its wiper is judged
	dpr_regmap #(.SEVEN_BIT(1'b1)) u_dut7 (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i),
		.cs_n_i(cs_n), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .addr_i(addr), .wdata_i(wdata),
		.hw_shutdown_n_i(hw_shutdown_n_i), .rdata_o(), .rvalid_o(),
		.command_error_o(), .wiper_code_o(wiper7), .switch_o());
	// ****************
	// shared tasks
	// ****************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic op(input dpr_pkg::dpr_cmd_t c, input logic [3:0] a, input logic [7:0] d);
		u_host.xfer(c, a, d);
		@(negedge clk_i);
	endtask : op
	task automatic rd(input logic [3:0] a);
		u_host.xfer(dpr_pkg::DPR_CMD_READ, a, 8'h00);
		rv = 1'b0;
		repeat (3)
		begin
			if (rvalid_o === 1'b1)
			begin
				rv = 1'b1;
				got = rdata_o;
			end
			@(negedge clk_i);
		end
	endtask : rd
	task automatic t_terminal_connect_control();
		check({5'h00, switch_o}, 8'h07);
		check(wiper7, 8'h3F);
		rd(4'h4);
		check(got, 8'hFF);
		op(dpr_pkg::DPR_CMD_WRITE, 4'h4, 8'h00);
		check({5'h00, switch_o}, 8'h07);
		rd(4'h4);
		check(got, 8'hF0);
		u_host.frame_end();
		repeat (3) @(negedge clk_i);
		check({5'h00, switch_o}, 8'h03);
		check(wiper_code_o, 8'h7F);
		op(dpr_pkg::DPR_CMD_WRITE, 4'h4, 8'h0D);
		u_host.frame_end();
		repeat (3) @(negedge clk_i);
		check({5'h00, switch_o}, 8'h05);
		hw_shutdown_n_i = 1'b0;
		op(dpr_pkg::DPR_CMD_WRITE, 4'h0, 8'h20);
		check({5'h00, switch_o}, 8'h03);
		check(wiper_code_o, 8'h20);
		hw_shutdown_n_i = 1'b1;
		repeat (2) @(negedge clk_i);
		check({5'h00, switch_o}, 8'h05);
	endtask : t_terminal_connect_control
	task automatic t_wiper();
		op(dpr_pkg::DPR_CMD_WRITE, 4'h0, 8'hFF);
		check(wiper7, 8'h7F);
		op(dpr_pkg::DPR_CMD_INCR, 4'h0, 8'h00);
		check(wiper_code_o, 8'hFF);
		check(wiper7, 8'h7F);
		op(dpr_pkg::DPR_CMD_DECR, 4'h0, 8'h00);
		check(wiper_code_o, 8'hFE);
		check(wiper7, 8'h7E);
		en_i = 1'b0;
		op(dpr_pkg::DPR_CMD_WRITE, 4'h0, 8'h00);
		en_i = 1'b1;
		check(wiper_code_o, 8'hFE);
		op(dpr_pkg::DPR_CMD_WRITE, 4'h0, 8'h00);
		op(dpr_pkg::DPR_CMD_DECR, 4'h0, 8'h00);
		rd(4'h0);
		check(got, 8'h00);
		check({7'h00, command_error_o}, 8'h00);
	endtask : t_wiper
	task automatic t_error();
		op(dpr_pkg::DPR_CMD_INCR, 4'h4, 8'h00);
		check({7'h00, command_error_o}, 8'h01);
		op(dpr_pkg::DPR_CMD_WRITE, 4'h0, 8'h55);
		check(wiper_code_o, 8'h00);
		u_host.frame_end();
		repeat (2) @(negedge clk_i);
		check({7'h00, command_error_o}, 8'h00);
		op(dpr_pkg::DPR_CMD_WRITE, 4'h2, 8'h55);
		check({7'h00, command_error_o}, 8'h01);
		check(wiper_code_o, 8'h00);
		u_host.frame_end();
		rd(4'hF);
		check({6'h00, rv, command_error_o}, 8'h01);
	endtask : t_error
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (6) @(negedge clk_i);
		nrst_i = 1'b1;
		@(negedge clk_i);
		t_terminal_connect_control();
		t_wiper();
		t_error();
		end_of_test();
	end
endmodule : dpr_regmap_tb
`default_nettype wire
